// [verilog/adc_host_end.sv]
// Host end: makes link clock and frames, collects results
`timescale 1ns/1ps
`default_nettype none
module adc_host_end (
   input  wire logic        mclk,
   input  wire logic        reset,
   adc_link_if.host         link,
   input  wire logic        useIntRef,
   input  wire logic        startReq,
   output logic [11:0]      sampleData,
   output logic             sampleValid,
   input  wire logic        sampleReady,
   output logic             powerReady
);
   typedef enum {Wake, Idle, Setup, Shift, Quiet} state_t;
   state_t       state_q;
   logic [15:0]  wait_q;
   logic [4:0]   periods_q;
   logic [1:0]   div_q;
   logic         sclk_q;
   logic         csN_q;
   logic [15:0]  shift_q;
   logic         sync1_q;
   logic         sync2_q;
   logic         push_q;
   logic         pwrOk_q;
   logic         fifoReady;
   wire  [15:0]  wakeCycles = useIntRef ?
      16'(adc_frame_pkg::PowerUpIntCycles) :
      16'(adc_frame_pkg::PowerUpExtCycles);
   // 50 percent duty clock from a fixed divider
   wire          halfDone = div_q == 2'(adc_frame_pkg::ClkHalfCycles - 1);
   wire          fallNow  = halfDone && sclk_q;
   wire          riseNow  = halfDone && !sclk_q;
   wire  [15:0]  gapCycles = 16'(adc_frame_pkg::AcquireCycles);
   assign link.serialClk = sclk_q;
   assign link.frameSelN = csN_q;
   assign powerReady     = pwrOk_q;
   // ********************************************************
   // Link sequencing
   // ********************************************************
   always_ff @(posedge mclk) begin
      sync1_q <= link.resultLine;
      sync2_q <= sync1_q;
   end
   always_ff @(posedge mclk) begin
      if (reset) begin
         state_q <= Wake;
         wait_q <= '0;
         periods_q <= '0;
         div_q <= '0;
         sclk_q <= 1'b1;
         csN_q <= 1'b1;
         shift_q <= '0;
         push_q <= 1'b0;
         pwrOk_q <= 1'b0;
      end else begin
         push_q <= 1'b0;
         div_q <= halfDone ? 2'h0 : div_q + 2'h1;
         case (state_q)
            Wake: begin
               wait_q <= wait_q + 16'h0001;
               if (wait_q >= wakeCycles) begin
                  pwrOk_q <= 1'b1;
                  state_q <= Idle;
               end
            end
            Idle: begin
               if (startReq && fifoReady && fallNow) begin
                  csN_q <= 1'b0;
                  state_q <= Setup;
               end
            end
            Setup: begin
               periods_q <= '0;
               // Clock stays high here; first fall comes in Shift
               if (halfDone) state_q <= Shift;
            end
            Shift: begin
               if (halfDone) sclk_q <= !sclk_q;
               // Sample late in the low phase, before next fall
               if (riseNow) shift_q <= {shift_q[14:0], sync2_q};
               if (fallNow) begin
                  periods_q <= periods_q + 5'h01;
                  if (periods_q ==
                      5'(adc_frame_pkg::FramePeriods - 1)) begin
                     state_q <= Quiet;
                  end
               end
            end
            Quiet: begin
               if (halfDone && !sclk_q) sclk_q <= 1'b1;
               if (!csN_q && riseNow) begin
                  // Last bit is taken on the closing rise
                  shift_q <= {shift_q[14:0], sync2_q};
                  csN_q <= 1'b1;
                  push_q <= 1'b1;
                  wait_q <= '0;
               end else if (csN_q) begin
                  wait_q <= wait_q + 16'h0001;
                  if (wait_q >= gapCycles) state_q <= Idle;
               end
            end
            default: state_q <= Wake;
         endcase
      end
   end
   // ********************************************************
   // Result buffer
   // ********************************************************
   sample_fifo #(.Width(12), .Depth(adc_frame_pkg::FifoDepth)) fifo (
      .mclk     (mclk),
      .reset    (reset),
      .inData   (shift_q[11:0]),
      .inValid  (push_q),
      .inReady  (fifoReady),
      .outData  (sampleData),
      .outValid (sampleValid),
      .outReady (sampleReady)
   );
endmodule
`default_nettype wire

// [verilog/adc_frame_pkg.sv]
// Shared constants for the serial converter frame link
// Function
// - Conversion lasts exactly sixteen serial clock periods
// - Host keeps clock duty within 40/60
// - Host leaves 100 ns quiet gap between frames
// - Host allows 300 ns track before sampling
// - Host waits 20 or 650 us after power-up
// - Frame select low enables result output drive
// - New bit after falling edge, old held
// - Output released after final falling edge
// - Early frame end releases output at once
// - Four zeros then twelve bits, MSB first
// - Frame select fall starts conversion and transfer
// - Serial clock alone paces the conversion
package adc_frame_pkg;
   localparam int unsigned MclkPeriodNs    = 25;
   localparam int unsigned FramePeriods    = 16;
   localparam int unsigned LeadZeros       = 4;
   localparam int unsigned ResultBits      = 12;
   localparam int unsigned TrackPeriod     = 13;
   localparam int unsigned QuietNs         = 100;
   localparam int unsigned AcquireNs       = 300;
   localparam int unsigned PowerUpExtUs    = 20;
   localparam int unsigned PowerUpIntUs    = 650;
   localparam int unsigned ClkHalfCycles   = 2;
   localparam int unsigned QuietCycles     =
      (QuietNs + MclkPeriodNs - 1) / MclkPeriodNs;
   localparam int unsigned AcquireCycles   =
      (AcquireNs + MclkPeriodNs - 1) / MclkPeriodNs;
   localparam int unsigned PowerUpExtCycles =
      (PowerUpExtUs * 1000 + MclkPeriodNs - 1) / MclkPeriodNs;
   localparam int unsigned PowerUpIntCycles =
      (PowerUpIntUs * 1000 + MclkPeriodNs - 1) / MclkPeriodNs;
   localparam int unsigned FifoDepth       = 16;
endpackage

// [verilog/adc_link_if.sv]
// Three-wire link between converter and host
`timescale 1ns/1ps
`default_nettype none
interface adc_link_if;
   logic serialClk;
   logic frameSelN;
   logic resultSerialOut;
   logic resultOe;
   logic resultLine;
   // Released line reads low, as with a pull-down
   assign resultLine = resultOe & resultSerialOut;
   modport device (input serialClk, input frameSelN,
                   output resultSerialOut, output resultOe);
   modport host   (output serialClk, output frameSelN,
                   input resultLine);
endinterface
`default_nettype wire

// [verilog/sample_fifo.sv]
// Word FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
   parameter int Width = 12,
   parameter int Depth = 16
) (
   input  wire logic             mclk,
   input  wire logic             reset,
   input  wire logic [Width-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady,
   output logic      [Width-1:0] outData,
   output logic                  outValid,
   input  wire logic             outReady
);
   localparam int Aw = $clog2(Depth);
   logic [Width-1:0] mem [Depth];
   logic [Aw-1:0]    wrPtr_q;
   logic [Aw-1:0]    rdPtr_q;
   logic [Aw:0]      count_q;
   wire              doWr = inValid && inReady;
   wire              doRd = outValid && outReady;
   assign inReady  = count_q != (Aw+1)'(Depth);
   assign outValid = count_q != '0;
   assign outData  = mem[rdPtr_q];
   always_ff @(posedge mclk) begin
      if (doWr) begin
         mem[wrPtr_q] <= inData;
      end
   end
   always_ff @(posedge mclk) begin
      if (reset) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end else begin
         if (doWr) wrPtr_q <= wrPtr_q + 1'b1;
         if (doRd) rdPtr_q <= rdPtr_q + 1'b1;
         count_q <= count_q + (Aw+1)'(doWr) - (Aw+1)'(doRd);
      end
   end
endmodule
`default_nettype wire

// [verilog/adc_device_end.sv]
// Converter end: clocked by the link clock and frame select only
`timescale 1ns/1ps
`default_nettype none
module adc_device_end (
   adc_link_if.device        link,
   input  wire logic [11:0]  analogCode,
   output logic              tracking
);
   // Count of falling edges within the frame
   logic [4:0]  edgeCnt_q;
   logic [11:0] held_q;
   logic        bit_q;
   logic        drive_q;
   logic        track_q;
   // Bit index presented after a falling edge
   wire  [4:0]  nextCnt = edgeCnt_q + 5'h01;
   wire  [3:0]  resIdx  = 4'(5'(adc_frame_pkg::FramePeriods) - 5'h01
                              - nextCnt);
   wire         inZeros = nextCnt < 5'(adc_frame_pkg::LeadZeros);
   wire         lastFall = nextCnt >= 5'(adc_frame_pkg::FramePeriods);
   // ********************************************************
   // Output drive
   // ********************************************************
   // Enable follows frame select directly so early rise releases at once
   assign link.resultOe        = drive_q && !link.frameSelN;
   assign link.resultSerialOut = bit_q;
   // Tracks between frames and again late in the frame
   assign tracking             = track_q || link.frameSelN;
   // ********************************************************
   // Conversion sequence on serial clock falling edges
   // ********************************************************
   always_ff @(negedge link.serialClk or posedge link.frameSelN) begin
      if (link.frameSelN) begin
         // First leading zero stands from frame select fall
         edgeCnt_q <= 5'h00;
         drive_q   <= 1'b1;
         bit_q     <= 1'b0;
      end else if (!lastFall) begin
         edgeCnt_q <= nextCnt;
         bit_q     <= inZeros ? 1'b0 : held_q[resIdx];
      end else begin
         drive_q   <= 1'b0;
      end
   end
   // Sample is held from frame start; tracking resumes late in frame
   always_ff @(negedge link.frameSelN) begin
      held_q <= analogCode;
   end
   always_ff @(negedge link.serialClk or posedge link.frameSelN) begin
      if (link.frameSelN) begin
         track_q <= 1'b0;
      end else begin
         track_q <= nextCnt >= 5'(adc_frame_pkg::TrackPeriod);
      end
   end
endmodule
`default_nettype wire

// [tb/adc_frame_properties.sv]
// Frame protocol checker for the converter link
`timescale 1ns/1ps
`default_nettype none
module adc_frame_properties (
   input wire logic mclk,
   input wire logic reset,
   input wire logic serialClk,
   input wire logic frameSelN,
   input wire logic resultSerialOut,
   input wire logic resultOe
);
   logic       sclk_q;
   logic [4:0] fallCnt_q;
   logic [4:0] hiCnt_q;
   wire        sclkFell = sclk_q & ~serialClk;
   wire  [4:0] fallTot  = fallCnt_q + 5'(sclkFell);
   wire  [4:0] fallCnt_d = (reset | frameSelN) ? 5'h00 : fallTot;
   wire  [4:0] hiCnt_d  = reset ? 5'h1f : ~frameSelN ? 5'h00 :
                          hiCnt_q + 5'(~&hiCnt_q);
   always_ff @(posedge mclk) begin
      sclk_q    <= serialClk;
      fallCnt_q <= fallCnt_d;
      hiCnt_q   <= hiCnt_d;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   sequence s_low_phase;
      !serialClk ##1 serialClk;
   endsequence
   a_oe_on_select: assert property ($fell(frameSelN) |-> ##[0:4] resultOe)
      else $error("output not driven after select");
   a_oe_off_deselect: assert property (frameSelN |-> !resultOe)
      else $error("output driven while deselected");
   a_lead_zero_bits: assert property (
      resultOe && fallTot < 5'h04 |-> !resultSerialOut)
      else $error("leading bit not zero");
   a_release_after_last: assert property (fallTot == 5'h10 |-> !resultOe)
      else $error("output not released after last fall");
   a_sixteen_periods: assert property (
      $rose(frameSelN) |-> fallTot == 5'h10)
      else $error("frame length not sixteen periods");
   a_quiet_gap_kept: assert property (
      $fell(frameSelN) |-> hiCnt_q >= 5'(adc_frame_pkg::AcquireCycles))
      else $error("gap between frames too short");
   a_clock_duty_half: assert property ($fell(serialClk) |=> s_low_phase)
      else $error("serial clock low phase wrong");
   a_bit_on_fall: assert property (
      resultOe && $past(resultOe) && $changed(resultSerialOut)
      |-> $fell(serialClk))
      else $error("data changed off falling edge");
endmodule
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for both link ends
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin testsRun++; if ((g) !== (e)) begin failures++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb;
   logic        mclk        = 1'b0;
   logic        reset       = 1'b1;
   logic        startReq    = 1'b1;
   logic        sampleReady = 1'b0;
   logic [11:0] analogCode  = 12'ha5c;
   logic [11:0] sampleData;
   logic        sampleValid;
   logic        powerReady;
   logic [11:0] word;
   logic        sawFrame;
   logic        useIntRef   = 1'b0;
   logic        faultTracking;
   logic [11:0] codes [4]   = '{12'h000, 12'hfff, 12'h801, 12'h7fe};
   int          failures    = 0;
   int          testsRun    = 0;
   adc_link_if i_adc_link_if ();
   adc_link_if i_adc_link_if_fault ();
   adc_device_end i_adc_device_end (.link(i_adc_link_if),
      .analogCode(analogCode), .tracking());
   adc_device_end i_adc_device_end_fault (.link(i_adc_link_if_fault),
      .analogCode(analogCode), .tracking(faultTracking));
   adc_host_end i_adc_host_end (.mclk(mclk), .reset(reset),
      .link(i_adc_link_if), .useIntRef(useIntRef), .startReq(startReq),
      .sampleData(sampleData), .sampleValid(sampleValid),
      .sampleReady(sampleReady), .powerReady(powerReady));
   adc_frame_properties i_adc_frame_properties (.mclk(mclk),
      .reset(reset), .serialClk(i_adc_link_if.serialClk),
      .frameSelN(i_adc_link_if.frameSelN),
      .resultSerialOut(i_adc_link_if.resultSerialOut),
      .resultOe(i_adc_link_if.resultOe));
   initial begin
      forever #12.5 mclk = ~mclk;
   end
   task automatic tick();
      @(posedge mclk);
      #2;
   endtask
   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", testsRun, failures);
      if (failures == 0 && testsRun > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic waitUntil(input int sel, input int lim);
      int   n;
      logic c;
      for (n = 0; n < lim; n++) begin
         c = sel == 0 ? powerReady :
             sel == 1 ? ~i_adc_link_if.frameSelN : sampleValid;
         if (c === 1'b1) break;
         tick();
      end
      if (n == lim) begin
         failures++;
         end_of_test();
      end
   endtask
   task automatic readWord();
      waitUntil(2, 400);
      word = sampleData;
      sampleReady = 1'b1;
      tick();
      sampleReady = 1'b0;
      tick();
   endtask
   initial begin
      i_adc_link_if_fault.serialClk = 1'b1;
      i_adc_link_if_fault.frameSelN = 1'b1;
      repeat (2) @(posedge mclk);
      #2;
      reset = 1'b0;
      repeat (790) tick();
      `CHK("wakeEarly", 1'b0, powerReady)
      `CHK("noFrameAsleep", 1'b1, i_adc_link_if.frameSelN)
      waitUntil(0, 20);
      repeat (2500) tick();
      sawFrame = 1'b0;
      repeat (200) begin
         tick();
         sawFrame |= ~i_adc_link_if.frameSelN;
      end
      `CHK("refusedWhenFull", 1'b0, sawFrame)
      startReq = 1'b0;
      repeat (adc_frame_pkg::FifoDepth) begin
         readWord();
         `CHK("fifoWord", 12'ha5c, word)
      end
      repeat (100) tick();
      `CHK("fifoEmpty", 1'b0, sampleValid)
      foreach (codes[i]) begin
         analogCode = codes[i];
         startReq = 1'b1;
         waitUntil(1, 200);
         startReq = 1'b0;
         readWord();
         `CHK("result", codes[i], word)
      end
      i_adc_link_if_fault.frameSelN = 1'b0;
      #15;
      repeat (3) begin
         i_adc_link_if_fault.serialClk = 1'b0;
         #15;
         i_adc_link_if_fault.serialClk = 1'b1;
         #15;
      end
      `CHK("oeInFrame", 1'b1, i_adc_link_if_fault.resultOe)
      `CHK("leadZero", 1'b0, i_adc_link_if_fault.resultLine)
      `CHK("trackHeld", 1'b0, faultTracking)
      i_adc_link_if_fault.frameSelN = 1'b1;
      #1;
      `CHK("oeAbort", 1'b0, i_adc_link_if_fault.resultOe)
      `CHK("lineFree", 1'b0, i_adc_link_if_fault.resultLine)
      `CHK("trackIdle", 1'b1, faultTracking)
      tick();
      useIntRef = 1'b1;
      startReq  = 1'b1;
      reset     = 1'b1;
      repeat (2) tick();
      `CHK("selInReset", 1'b1, i_adc_link_if.frameSelN)
      `CHK("readyInReset", 1'b0, powerReady)
      reset = 1'b0;
      repeat (25990) tick();
      `CHK("intRefEarly", 1'b0, powerReady)
      `CHK("noFrameAsleepInt", 1'b1, i_adc_link_if.frameSelN)
      waitUntil(0, 20);
      waitUntil(1, 20);
      end_of_test();
   end
endmodule
`default_nettype wire
